// ### rtl/mcg_map.svh
// Address map, field positions, reset values and counts of the clock
// generator. Definitions only; included by the package, the clock generator and the bench files.
`ifndef MCG_MAP_SVH
`define MCG_MAP_SVH

// ----------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------
`define MCG_ADDR_W            32
`define MCG_PCC_ADDR          32'hFFFFF828
`define MCG_PROT_CMD_ADDR     32'hFFFFF1FC

// ----------------------------------------------------------------------
// Processor clock control fields
// ----------------------------------------------------------------------
`define MCG_BIT_SUB_FB_OFF    7
`define MCG_BIT_MAIN_STOP     6
`define MCG_BIT_MAIN_FB_OFF   5
`define MCG_BIT_STATUS        4
`define MCG_BIT_SUB_SEL       3
`define MCG_BIT_RSVD          2
`define MCG_BIT_DIV_HI        1
`define MCG_BIT_DIV_LO        0
`define MCG_PCC_RESET         8'h03

// ----------------------------------------------------------------------
// Divider widths and timing counts
// ----------------------------------------------------------------------
`define MCG_PRE1_W            11
`define MCG_PRE2_W            3
`define MCG_WDT_W             4
`define MCG_OST_W             16
`define MCG_OST_CYCLES        16'h0400

`endif

// ### rtl/mcg_pkg.sv
// Types shared by the clock generator modules.
// Assumes mcg_map.svh sits beside it on the include path.
`include "mcg_map.svh"

package mcg_pkg;

    // ------------------------------------------------------------------
    // CPU clock source state, Gray coded around the switch loop
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        MCG_SRC_MAIN    = 2'b00,
        MCG_SRC_TO_SUB  = 2'b01,
        MCG_SRC_SUB     = 2'b11,
        MCG_SRC_TO_MAIN = 2'b10
    } mcg_src_t;

endpackage : mcg_pkg

// ### rtl/mcg_sync.sv
// Three-stage synchroniser for one asynchronous pin.
// Assumes the pin is slow against i_clk_sys; a change is taken only
// once the second and third stages agree.
`timescale 1ns/1ps

module mcg_sync
(
    // Clock and reset
    input  wire logic i_clk_sys,
    input  wire logic i_sys_rst,
    // Pin and clean level
    input  wire logic i_pin,
    output logic      o_level
);

    logic stage1_r;
    logic stage2_r;
    logic stage3_r;
    logic level_r;

    // ------------------------------------------------------------------
    // Sampling chain
    // ------------------------------------------------------------------
    // Chain of three, first stage feeds only the second
    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst)
        begin
            stage1_r <= 1'b0;
            stage2_r <= 1'b0;
            stage3_r <= 1'b0;
            level_r  <= 1'b0;
        end
        else
        begin
            stage1_r <= i_pin;
            stage2_r <= stage1_r;
            stage3_r <= stage2_r;
            if (stage2_r == stage3_r)
                level_r <= stage3_r;
        end
    end

    assign o_level = level_r;

endmodule : mcg_sync

// ### rtl/mcg_prescale.sv
// Binary prescaler giving one-cycle ticks at 1/1 .. 1/2**W of the
// enabled input rate. Assumes i_run marks each input clock cycle.
`timescale 1ns/1ps

module mcg_prescale
#(
    parameter int W = 3
)
(
    // Clock and reset
    input  wire logic         i_clk_sys,
    input  wire logic         i_sys_rst,
    // Count enable and divided ticks
    input  wire logic         i_run,
    output logic [W:0]        o_tick
);

    logic [W-1:0] cnt_r;

    // ------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------
    // Advances only on enabled cycles
    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst)
            cnt_r <= '0;
        else if (i_run)
            cnt_r <= cnt_r + 1'b1;
    end

    // Tick k fires when the low k bits are all ones
    assign o_tick[0] = i_run;
    genvar k;
    generate
        for (k = 1; k <= W; k++)
        begin : g_tick
            assign o_tick[k] = i_run & (&cnt_r[k-1:0]);
        end
    endgenerate

endmodule : mcg_prescale

// ### rtl/mcg_clock_gen.sv
// Clock generator: oscillator control, CPU clock source switch,
// prescalers, watchdog clock, clock output pin, protected control reg.
// Assumes one system clock; derived clocks leave as one-cycle ticks.
// Subclock arrives as an asynchronous square wave on a pin.
//
// Overview of operation
// R1: Main oscillator halts in STOP on main clock, or stop bit on sub.
// R2: Subclock oscillator halts when STOP is entered while on subclock.
// R3: First prescaler gives main clock divided by 1 up to 2048.
// R4: Second prescaler divides main clock by 1, 2, 4, 8 for selector.
// R5: Watchdog clock is main oscillator over 16; watchdog stops on sub.
// R6: Control register changes only on a write inside the unlock sequence.
// R7: Control register is byte and bit accessible, resets to 03H.
// R8: Status flag reads 0 on main, 1 on subclock; writes ignored.
// R9: Select bits pick main /1 /2 /4 /8; top bit set picks subclock.
// R10: Stop bit stops main oscillator, but only once CPU is on subclock.
// R11: Feedback resistor bits enable resistor at 0, disable at 1.
// R12: Switch to subclock finishes within one subclock period.
// R13: Switch back to main finishes within one subclock period.
// R14: Software restarts main and waits stabilisation before switching back.
// R15: Software keeps clock select fixed while clock output is driving.
// R16: Software always writes bit 2 of the control register as zero.
// R17: Wait on subclock with main absent releases only by reset.
// R18: Clocks run or stop by state; CPU stops in reset, OST, IDLE, STOP.
// R19: Watchdog clock may toggle on subclock, but watchdog itself stops.
// R20: Clock output pin drives system clock when running, low when stopped.
// R21: After reset the clock output pin is undriven until selected.
// R22: External clock needs main resistor off; stabilisation still inserted.
// R23: Write to protection command arms one write; other access disarms.
`timescale 1ns/1ps
`include "mcg_map.svh"

module mcg_clock_gen
    import mcg_pkg::*;
#(
    parameter logic [`MCG_OST_W-1:0] OST_CYCLES = `MCG_OST_CYCLES
)
(
    // Clock and reset
    input  wire logic                   i_clk_sys,
    input  wire logic                   i_sys_rst,
    // Register port
    input  wire logic [`MCG_ADDR_W-1:0] i_reg_addr,
    input  wire logic [7:0]             i_reg_wdata,
    input  wire logic                   i_reg_wr,
    input  wire logic                   i_reg_rd,
    output logic [7:0]                  o_reg_rdata,
    // Operating state from the standby controller
    input  wire logic                   i_stop_mode,
    input  wire logic                   i_idle_mode,
    input  wire logic                   i_wait_req,
    input  wire logic                   i_port_cm_mode_control,
    // Subclock square wave from the sub oscillator
    input  wire logic                   i_sub_osc_pin,
    // Oscillator controls
    output logic                        o_main_osc_en,
    output logic                        o_sub_osc_en,
    output logic                        o_main_fb_res_off,
    output logic                        o_sub_fb_res_off,
    // Derived clock ticks
    output logic                        o_cpu_tick,
    output logic                        o_sys_tick,
    output logic [`MCG_PRE1_W:0]        o_periph_tick,
    output logic                        o_wdt_tick,
    output logic                        o_wdt_run,
    // Status and stall
    output logic                        o_cpu_clock_status,
    output logic                        o_wait_lock,
    // Clock output pin
    output logic                        o_clock_output_pin,
    output logic                        o_clock_output_pin_oe
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic                   sub_fb_off_r;
    logic                   main_osc_stop_bit_r;
    logic                   main_fb_off_r;
    logic                   subclock_select_bit_r;
    logic                   divider_select_hi_r;
    logic                   divider_select_lo_r;
    logic                   armed_r;
    mcg_src_t               src_r;
    mcg_src_t               src_nxt;
    logic [`MCG_OST_W-1:0]  ost_cnt_r;
    logic                   sub_level;
    logic                   sub_level_d_r;
    logic                   wait_lock_r;
    logic                   clock_output_pin_phase_r;
    logic                   clock_output_pin_oe_r;
    logic [7:0]             rdata_r;
    logic                   cpu_tick_r;
    logic                   sys_tick_r;
    logic [`MCG_PRE1_W:0]   periph_tick_r;
    logic                   wdt_tick_r;
    logic                   wdt_run_r;
    logic                   main_osc_en_r;
    logic                   sub_osc_en_r;
    logic [`MCG_PRE1_W:0]   pre1_tick;
    logic [`MCG_PRE2_W:0]   pre2_tick;
    logic [`MCG_WDT_W:0]    wdt_div_tick;

    // ------------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------------
    wire hit_pcc      = (i_reg_addr == `MCG_PCC_ADDR);
    wire hit_prot     = (i_reg_addr == `MCG_PROT_CMD_ADDR);
    wire any_access   = i_reg_wr | i_reg_rd;
    wire prot_wr      = i_reg_wr & hit_prot;
    wire pcc_wr_ok    = i_reg_wr & hit_pcc & armed_r;       // R6
    wire status_flag  = (src_r == MCG_SRC_SUB) |
                        (src_r == MCG_SRC_TO_MAIN);         // R8

    // Read view; bit 2 reads zero, status comes from the switch
    wire [7:0] pcc_view = {sub_fb_off_r, main_osc_stop_bit_r,
                           main_fb_off_r, status_flag,
                           subclock_select_bit_r, 1'b0,
                           divider_select_hi_r, divider_select_lo_r};
    wire [7:0] rdata_nxt = (i_reg_rd & hit_pcc) ? pcc_view : 8'h00;

    // ------------------------------------------------------------------
    // Oscillator halt conditions
    // ------------------------------------------------------------------
    // Main stops in STOP on main, or by stop bit once on subclock
    wire main_halt = (i_stop_mode & ~status_flag) |
                     (main_osc_stop_bit_r & status_flag);   // R1 R10
    // Subclock stops only in STOP while on subclock
    wire sub_halt  = i_stop_mode & status_flag;             // R2
    wire main_on   = ~main_halt;
    wire main_ok   = main_on & (ost_cnt_r == '0);           // R22

    // ------------------------------------------------------------------
    // Subclock edge detection
    // ------------------------------------------------------------------
    // Rising edge of the cleaned subclock, ignored while halted
    wire sub_edge  = sub_level & ~sub_level_d_r & ~sub_halt;

    // ------------------------------------------------------------------
    // Run conditions by operating state
    // ------------------------------------------------------------------
    wire core_run   = ~i_idle_mode & ~i_stop_mode;          // R18
    wire fxx_run    = main_ok & core_run;
    wire periph_run = main_ok & core_run;                   // R3
    wire wdt_clk_on = main_on & core_run;                   // R5 R19

    // ------------------------------------------------------------------
    // CPU and system clock selection
    // ------------------------------------------------------------------
    wire [1:0] div_sel  = {divider_select_hi_r, divider_select_lo_r};
    wire main_sel_tick  = pre2_tick[div_sel];               // R9 R4
    wire cpu_tick_nxt   = status_flag ? (sub_edge & core_run)
                                      : (main_sel_tick & main_ok);
    // Wait lock freezes the CPU, never the system clock source
    wire cpu_run_nxt    = cpu_tick_nxt & ~wait_lock_r;      // R17

    // ------------------------------------------------------------------
    // Wait lock condition
    // ------------------------------------------------------------------
    wire lock_set = status_flag & ~main_ok & i_wait_req;    // R17

    // ------------------------------------------------------------------
    // Source switch next state
    // ------------------------------------------------------------------
    // Each switch completes on a subclock rising edge, the one back to main only once main_ok
    always_comb
    begin
        src_nxt = src_r;
        case (src_r)
            MCG_SRC_MAIN:
                if (subclock_select_bit_r)
                    src_nxt = MCG_SRC_TO_SUB;
            MCG_SRC_TO_SUB:
                if (!subclock_select_bit_r)
                    src_nxt = MCG_SRC_MAIN;
                else if (sub_edge)
                    src_nxt = MCG_SRC_SUB;                  // R12
            MCG_SRC_SUB:
                if (!subclock_select_bit_r)
                    src_nxt = MCG_SRC_TO_MAIN;
            MCG_SRC_TO_MAIN:
                if (subclock_select_bit_r)
                    src_nxt = MCG_SRC_SUB;
                else if (sub_edge && main_ok)
                    src_nxt = MCG_SRC_MAIN;                 // R13 R14
            default:
                src_nxt = MCG_SRC_MAIN;
        endcase
    end

    // ------------------------------------------------------------------
    // Prescaler instances
    // ------------------------------------------------------------------
    // First prescaler: peripheral ticks fxx .. fxx/2048
    mcg_prescale #(.W(`MCG_PRE1_W)) u_pre1
    (
        .i_clk_sys (i_clk_sys),
        .i_sys_rst (i_sys_rst),
        .i_run     (periph_run),
        .o_tick    (pre1_tick)
    );

    // Second prescaler: fxx .. fxx/8 for the CPU clock selector
    mcg_prescale #(.W(`MCG_PRE2_W)) u_pre2
    (
        .i_clk_sys (i_clk_sys),
        .i_sys_rst (i_sys_rst),
        .i_run     (fxx_run),
        .o_tick    (pre2_tick)
    );

    // Watchdog divider: fx/16, runs during stabilisation too
    mcg_prescale #(.W(`MCG_WDT_W)) u_wdt_div
    (
        .i_clk_sys (i_clk_sys),
        .i_sys_rst (i_sys_rst),
        .i_run     (wdt_clk_on),
        .o_tick    (wdt_div_tick)
    );

    // Subclock pin synchroniser
    mcg_sync u_sub_sync
    (
        .i_clk_sys (i_clk_sys),
        .i_sys_rst (i_sys_rst),
        .i_pin     (i_sub_osc_pin),
        .o_level   (sub_level)
    );

    // ------------------------------------------------------------------
    // Protected control register
    // ------------------------------------------------------------------
    // Reset value 03H; bit 2 and status are not stored
    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst)
        begin
            sub_fb_off_r          <= 1'(`MCG_PCC_RESET >> `MCG_BIT_SUB_FB_OFF);
            main_osc_stop_bit_r   <= 1'b0;
            main_fb_off_r         <= 1'b0;
            subclock_select_bit_r <= 1'b0;
            divider_select_hi_r   <= 1'b1;                  // R7
            divider_select_lo_r   <= 1'b1;                  // R7
        end
        else if (pcc_wr_ok)                                 // R6 R8
        begin
            sub_fb_off_r          <= i_reg_wdata[`MCG_BIT_SUB_FB_OFF];
            main_osc_stop_bit_r   <= i_reg_wdata[`MCG_BIT_MAIN_STOP];
            main_fb_off_r         <= i_reg_wdata[`MCG_BIT_MAIN_FB_OFF];
            subclock_select_bit_r <= i_reg_wdata[`MCG_BIT_SUB_SEL];
            divider_select_hi_r   <= i_reg_wdata[`MCG_BIT_DIV_HI];
            divider_select_lo_r   <= i_reg_wdata[`MCG_BIT_DIV_LO];
        end
    end

    // ------------------------------------------------------------------
    // Unlock sequence
    // ------------------------------------------------------------------
    // Protection write arms; any other access spends or drops it
    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst)
            armed_r <= 1'b0;
        else if (prot_wr)
            armed_r <= 1'b1;                                // R23
        else if (any_access)
            armed_r <= 1'b0;                                // R23
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    // Valid only in the cycle after the read strobe
    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst)
            rdata_r <= 8'h00;
        else
            rdata_r <= rdata_nxt;
    end

    // ------------------------------------------------------------------
    // Oscillation stabilisation counter
    // ------------------------------------------------------------------
    // Restarts whenever the main oscillator is halted
    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst)
            ost_cnt_r <= OST_CYCLES;
        else if (!main_on)
            ost_cnt_r <= OST_CYCLES;                        // R22
        else if (ost_cnt_r != '0)
            ost_cnt_r <= ost_cnt_r - 1'b1;
    end

    // ------------------------------------------------------------------
    // Source switch state and subclock edge memory
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst)
        begin
            src_r         <= MCG_SRC_MAIN;
            sub_level_d_r <= 1'b0;
        end
        else
        begin
            src_r         <= src_nxt;
            sub_level_d_r <= sub_level;
        end
    end

    // ------------------------------------------------------------------
    // Wait lock
    // ------------------------------------------------------------------
    // Sticky until reset; nothing else clears it
    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst)
            wait_lock_r <= 1'b0;
        else if (lock_set)
            wait_lock_r <= 1'b1;                            // R17
    end

    // ------------------------------------------------------------------
    // Clock ticks and oscillator controls
    // ------------------------------------------------------------------
    // All zero during reset, so every derived clock stops
    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst)
        begin
            cpu_tick_r    <= 1'b0;
            sys_tick_r    <= 1'b0;
            periph_tick_r <= '0;
            wdt_tick_r    <= 1'b0;
            wdt_run_r     <= 1'b0;
            main_osc_en_r <= 1'b0;
            sub_osc_en_r  <= 1'b0;
        end
        else
        begin
            cpu_tick_r    <= cpu_run_nxt;                   // R18
            sys_tick_r    <= cpu_tick_nxt;                  // R18
            periph_tick_r <= pre1_tick;                     // R3
            wdt_tick_r    <= wdt_div_tick[`MCG_WDT_W];      // R5
            wdt_run_r     <= ~status_flag & wdt_clk_on;     // R19
            main_osc_en_r <= main_on;                       // R1
            sub_osc_en_r  <= ~sub_halt;                     // R2
        end
    end

    // ------------------------------------------------------------------
    // Clock output pin
    // ------------------------------------------------------------------
    // Toggles per system tick, low while the system clock is stopped
    always_ff @(posedge i_clk_sys)
    begin
        if (i_sys_rst)
        begin
            clock_output_pin_phase_r <= 1'b0;
            clock_output_pin_oe_r    <= 1'b0;                         // R21
        end
        else
        begin
            clock_output_pin_oe_r <= i_port_cm_mode_control;          // R21
            if (!core_run || !(status_flag || main_ok))
                clock_output_pin_phase_r <= 1'b0;                     // R20
            else if (cpu_tick_nxt)
                clock_output_pin_phase_r <= ~clock_output_pin_phase_r;          // R20
        end
    end

    // ------------------------------------------------------------------
    // Output assignments
    // ------------------------------------------------------------------
    assign o_reg_rdata           = rdata_r;
    assign o_main_osc_en         = main_osc_en_r;
    assign o_sub_osc_en          = sub_osc_en_r;
    assign o_main_fb_res_off     = main_fb_off_r;           // R11
    assign o_sub_fb_res_off      = sub_fb_off_r;            // R11
    assign o_cpu_tick            = cpu_tick_r;
    assign o_sys_tick            = sys_tick_r;
    assign o_periph_tick         = periph_tick_r;
    assign o_wdt_tick            = wdt_tick_r;
    assign o_wdt_run             = wdt_run_r;
    assign o_cpu_clock_status    = src_r[1];                // R8
    assign o_wait_lock           = wait_lock_r;
    assign o_clock_output_pin    = clock_output_pin_phase_r;
    assign o_clock_output_pin_oe = clock_output_pin_oe_r;

endmodule : mcg_clock_gen

// ### tb/mcg_sub_xtal.sv
// Behavioural subclock crystal: square wave while enabled.
// Assumes the enable comes from the clock generator's sub control.
`timescale 1ns/1ps

module mcg_sub_xtal
#(
    parameter int HALF_NS = 837
)
(
    input  wire logic i_osc_en,
    output logic      o_sub_wave
);
    // Free phase against the system clock, low when halted
    initial
    begin
        o_sub_wave = 1'h0;
        forever
        begin
            #(HALF_NS);
            o_sub_wave = i_osc_en ? !o_sub_wave : 1'h0;
        end
    end
endmodule : mcg_sub_xtal

// ### tb/mcg_clock_gen_asserts.sv
// Port checks of the clock generator, bound into its top module.
// Assumes register strobes are one-cycle pulses.
`timescale 1ns/1ps
`include "mcg_map.svh"

module mcg_clock_gen_asserts
(
    input wire logic        i_clk_sys,
    input wire logic        i_sys_rst,
    input wire logic [31:0] i_reg_addr,
    input wire logic [7:0]  i_reg_wdata,
    input wire logic        i_reg_wr,
    input wire logic        i_reg_rd,
    input wire logic [7:0]  o_reg_rdata,
    input wire logic        i_stop_mode,
    input wire logic        i_idle_mode,
    input wire logic        i_port_cm_mode_control,
    input wire logic        o_main_osc_en,
    input wire logic        o_main_fb_res_off,
    input wire logic        o_sub_fb_res_off,
    input wire logic        o_cpu_tick,
    input wire logic        o_wdt_run,
    input wire logic        o_cpu_clock_status,
    input wire logic        o_wait_lock,
    input wire logic        o_clock_output_pin,
    input wire logic        o_clock_output_pin_oe
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_sys_rst);
    // Access decode and one-cycle history of it
    wire  pcc_wr = i_reg_wr && i_reg_addr == `MCG_PCC_ADDR;
    wire  pcc_rd = i_reg_rd && i_reg_addr == `MCG_PCC_ADDR;
    wire  stby   = i_idle_mode || i_stop_mode;
    logic arm_r;
    logic rd_pcc_r;
    always_ff @(posedge i_clk_sys)
    begin
        arm_r    <= !i_sys_rst && ((i_reg_wr && i_reg_addr ==
                    `MCG_PROT_CMD_ADDR) || (arm_r && !i_reg_wr && !i_reg_rd));
        rd_pcc_r <= !i_sys_rst && pcc_rd;
    end
    a_rdata_quiet: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 8'h00)
        else $error("read data outside read slot");
    a_bit2_zero: assert property (rd_pcc_r |-> !o_reg_rdata[2])
        else $error("reserved bit reads one");
    a_fb_readback: assert property (rd_pcc_r |-> o_reg_rdata[5] == o_main_fb_res_off && o_reg_rdata[7] == o_sub_fb_res_off)
        else $error("feedback pins differ from register");
    a_locked_write: assert property (pcc_wr && !arm_r |=> $stable(o_main_fb_res_off))
        else $error("unarmed write changed register");
    a_armed_write: assert property (pcc_wr && arm_r |=> o_main_fb_res_off == $past(i_reg_wdata[5]))
        else $error("armed write not taken");
    a_oe_follow: assert property (1'h1 |=> o_clock_output_pin_oe == $past(i_port_cm_mode_control))
        else $error("output enable wrong");
    a_pin_standby: assert property (stby [*2] |-> !o_clock_output_pin)
        else $error("clock pin active in standby");
    a_cpu_standby: assert property (stby [*2] |-> !o_cpu_tick)
        else $error("cpu tick in standby");
    a_main_halt: assert property ((i_stop_mode && !o_cpu_clock_status) [*2] |-> !o_main_osc_en)
        else $error("main oscillator runs in stop");
    a_wdt_on_sub: assert property (o_cpu_clock_status [*2] |-> !o_wdt_run)
        else $error("watchdog runs on subclock");
    a_lock_sticky: assert property (o_wait_lock |=> o_wait_lock)
        else $error("wait lock released");
    cover property (pcc_wr && arm_r);
    cover property ($rose(o_cpu_clock_status));
    cover property ($rose(o_wait_lock));
endmodule : mcg_clock_gen_asserts

bind mcg_clock_gen mcg_clock_gen_asserts i_chk (.*);

// ### tb/test_mcu_clock_generator.sv
// Self-checking bench of the clock generator with a subclock crystal.
// Assumes the register map header and the short stabilisation count.
`timescale 1ns/1ps
`include "mcg_map.svh"

module test_mcu_clock_generator;
    logic i_clk_sys = 0, i_sys_rst = 1, i_reg_wr = 0, i_reg_rd = 0;
    logic i_stop_mode = 0, i_idle_mode = 0, i_wait_req = 0;
    logic i_port_cm_mode_control = 0, i_sub_osc_pin;
    logic [31:0] i_reg_addr = 0;
    logic [7:0] i_reg_wdata = 0, o_reg_rdata;
    logic o_main_osc_en, o_sub_osc_en, o_main_fb_res_off, o_sub_fb_res_off;
    logic o_cpu_tick, o_sys_tick, o_wdt_tick, o_wdt_run, o_cpu_clock_status;
    logic o_wait_lock, o_clock_output_pin, o_clock_output_pin_oe;
    logic [11:0] o_periph_tick;
    int err_total = 0, cmp_count = 0, n, w;
    mcg_clock_gen #(.OST_CYCLES(16'h0008)) i_dut (.*);
    mcg_sub_xtal i_xtal (.i_osc_en(o_sub_osc_en), .o_sub_wave(i_sub_osc_pin));
    initial forever #50 i_clk_sys = ~i_clk_sys;
    task stop_test;
        if (err_total == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : stop_test
    task chk(input logic [11:0] seen, input logic [11:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // One bus cycle, then sits 1 ns after the answer edge
    task acc(input logic wr, input logic [31:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        {i_reg_wr, i_reg_rd, i_reg_addr, i_reg_wdata} <= {wr, !wr, a, d};
        @(posedge i_clk_sys);
        {i_reg_wr, i_reg_rd} <= 2'h0;
        #1;
    endtask : acc
    task rdc(input logic [31:0] a, input logic [7:0] exp);
        acc(1'h0, a, 8'h00);
        chk(o_reg_rdata, exp);
    endtask : rdc
    task pw(input logic [7:0] d);
        acc(1'h1, `MCG_PROT_CMD_ADDR, 8'h00);
        acc(1'h1, `MCG_PCC_ADDR, d);
    endtask : pw
    task cyc(input int k);
        repeat (k) @(posedge i_clk_sys);
        #1;
    endtask : cyc
    task wait_st(input logic exp);
        for (n = 0; o_cpu_clock_status !== exp; n++)
        begin
            if (n == 24) begin err_total++; stop_test(); end
            cyc(1);
        end
    endtask : wait_st
    task rst_seq;
        i_sys_rst <= 1;
        repeat (5) @(posedge i_clk_sys);
        i_sys_rst <= 0;
    endtask : rst_seq
    // Main sequence
    initial
    begin
        rst_seq();
        rdc(`MCG_PCC_ADDR, 8'h03);
        rdc(32'hFFFFF82C, 8'h00);
        acc(1'h1, `MCG_PCC_ADDR, 8'hA0);
        rdc(`MCG_PCC_ADDR, 8'h03);
        acc(1'h1, `MCG_PROT_CMD_ADDR, 8'h00);
        acc(1'h0, `MCG_PCC_ADDR, 8'h00);
        acc(1'h1, `MCG_PCC_ADDR, 8'hA0);
        rdc(`MCG_PCC_ADDR, 8'h03);
        for (int k = 0; k < 4; k++)
        begin
            pw(8'(k));
            rdc(`MCG_PCC_ADDR, 8'(k));
            n = 0; w = 0;
            repeat (64) begin cyc(1); n += o_sys_tick; w += o_wdt_tick; end
            chk(n >= (64 >> k) - 1 && n <= (64 >> k) + 1, 1);
            chk(w >= 3 && w <= 5, 1);
        end
        pw(8'hB1);
        rdc(`MCG_PCC_ADDR, 8'hA1);
        chk({o_sub_fb_res_off, o_main_fb_res_off}, 2'h3);
        pw(8'h09); wait_st(1);
        rdc(`MCG_PCC_ADDR, 8'h19);
        chk(o_wdt_run, 0);
        pw(8'h49); cyc(3);
        chk(o_main_osc_en, 0);
        pw(8'h09); cyc(12); pw(8'h01); wait_st(0);
        rdc(`MCG_PCC_ADDR, 8'h01);
        pw(8'h09); wait_st(1); pw(8'h49);
        i_wait_req <= 1; cyc(3); i_wait_req <= 0; cyc(3);
        chk(o_wait_lock, 1);
        rst_seq(); cyc(1);
        chk(o_wait_lock, 0);
        i_port_cm_mode_control <= 1; cyc(14);
        chk(o_clock_output_pin_oe, 1);
        i_idle_mode <= 1; cyc(3);
        chk({o_clock_output_pin, o_cpu_tick}, 0);
        {i_idle_mode, i_stop_mode} <= 2'h1; cyc(3);
        chk(o_main_osc_en, 0);
        stop_test();
    end
endmodule : test_mcu_clock_generator
